// *** design/wcw_pkg.sv ***
// Purpose: shared constants and types of the countdown watchdog
// Assumes: one 50 MHz clock that doubles as the oscillator clock
// Notes:   timebase tables come from the clock controller selection
package wcw_pkg;

    // control register placement and layout
    localparam logic [7:0] WCW_CTRL_ADDR  = 8'h2A;
    localparam logic [7:0] WCW_CTRL_RESET = 8'h7F;
    localparam int         WCW_ACT_POS    = 7;
    localparam int         WCW_TOP_POS    = 6;
    localparam int         WCW_COUNT_W    = 7;
    localparam logic [6:0] WCW_TIMEOUT_AT = 7'h40;
    localparam logic [7:0] WCW_READ_IDLE  = 8'h00;

    // prescaler figures
    localparam int WCW_PRESCALE_CYCLES = 16384;
    localparam int WCW_SHORT_BASE      = 192;
    localparam int WCW_STEP_UNIT       = 64;
    localparam int WCW_ACC_STEP        = 4;

    // reset pulse timing
    localparam int WCW_CLOCK_PERIOD_NS = 20;
    localparam int WCW_RESET_PULSE_NS  = 500;
    localparam int WCW_PULSE_RAW       =
        WCW_RESET_PULSE_NS / WCW_CLOCK_PERIOD_NS;
    localparam int WCW_RESET_PULSE_CYCLES =
        (WCW_PULSE_RAW < 1) ? 1 : WCW_PULSE_RAW;

    typedef struct packed {
        logic       activate;
        logic [6:0] count;
    } wcw_ctrl_type;

    typedef enum logic [1:0] {
        WCW_RUN,
        WCW_HALT,
        WCW_ACTIVE_HALT
    } wcw_halt_type;

    // per-timebase constant pair: step period multiple and short step offset
    function automatic logic [5:0] wcw_msb(input logic [1:0] sel);
        case (sel)
            2'h0:    wcw_msb = 6'h04;
            2'h1:    wcw_msb = 6'h08;
            2'h2:    wcw_msb = 6'h14;
            default: wcw_msb = 6'h31;
        endcase
    endfunction : wcw_msb

    function automatic logic [5:0] wcw_lsb(input logic [1:0] sel);
        case (sel)
            2'h0:    wcw_lsb = 6'h3B;
            2'h1:    wcw_lsb = 6'h35;
            2'h2:    wcw_lsb = 6'h23;
            default: wcw_lsb = 6'h36;
        endcase
    endfunction : wcw_lsb

endpackage : wcw_pkg

// *** design/wcw_prescaler.sv ***
// Purpose: free-running step generator for the watchdog counter
// Assumes: LONG_CYCLES >= (192 + largest LSB) * STEP_UNIT
// Notes:   one step in MSB/4 is shortened to track the timebase
`timescale 1ns/100ps
`default_nettype none
module wcw_prescaler #(
    parameter int LONG_CYCLES = wcw_pkg::WCW_PRESCALE_CYCLES,
    parameter int STEP_UNIT   = wcw_pkg::WCW_STEP_UNIT
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // timebase from the clock controller
    input  wire logic [1:0] timebase_select,
    // one-cycle pulse per counter step
    output var  logic       step
);
    localparam int PW = $clog2(LONG_CYCLES + 1);

    logic [PW-1:0] phase;
    logic [5:0]    acc;
    logic [6:0]    acc_sum;
    logic          short_next;
    logic [PW-1:0] next_len;
    logic [5:0]    msb;
    logic [5:0]    lsb;

    always_comb
    begin
        msb        = wcw_pkg::wcw_msb(timebase_select);
        lsb        = wcw_pkg::wcw_lsb(timebase_select);
        acc_sum    = {1'b0, acc} + 7'(wcw_pkg::WCW_ACC_STEP);
        short_next = acc_sum >= {1'b0, msb};
        if (short_next)
            next_len = PW'((wcw_pkg::WCW_SHORT_BASE + int'(lsb)) * STEP_UNIT);
        else
            next_len = PW'(LONG_CYCLES);
    end

    // never cleared by a reload, so timeouts spread between bounds
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            phase <= PW'(LONG_CYCLES - 1);
            acc   <= '0;
            step  <= 1'b0;
        end
        else if (phase == '0)
        begin
            phase <= next_len - PW'(1);
            acc   <= short_next ? 6'(acc_sum - {1'b0, msb}) : acc_sum[5:0];
            step  <= 1'b1;
        end
        else
        begin
            phase <= phase - PW'(1);
            step  <= 1'b0;
        end
    end

    a_step_spacing: assert property (@(posedge clock) disable iff (!reset_n)
        step |=> !step [*8])
        else $error("prescaler steps too close together");

    a_step_reload: assert property (@(posedge clock) disable iff (!reset_n)
        (phase == '0) |=> step && phase == $past(next_len) - PW'(1))
        else $error("prescaler step length wrong");

endmodule : wcw_prescaler
`default_nettype wire

// *** design/wcw_reset_pulse.sv ***
// Purpose: stretch a reset request into a fixed low pulse
// Assumes: requests during a pulse are absorbed by it
// Notes:   output is a flop, low while the pulse runs
`timescale 1ns/100ps
`default_nettype none
module wcw_reset_pulse #(
    parameter int PULSE_CYCLES = wcw_pkg::WCW_RESET_PULSE_CYCLES
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    // request and pulse
    input  wire logic start,
    output var  logic pulse_n
);
    localparam int CW         = $clog2(PULSE_CYCLES + 1);
    localparam int PULSE_HOLD = PULSE_CYCLES - 1;

    logic [CW-1:0] remain;

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            pulse_n <= 1'b1;
            remain  <= '0;
        end
        else if (pulse_n && start)
        begin
            pulse_n <= 1'b0;
            remain  <= CW'(PULSE_CYCLES - 1);
        end
        else if (!pulse_n)
        begin
            if (remain == '0)
                pulse_n <= 1'b1;
            else
                remain <= remain - CW'(1);
        end
    end

    a_pulse_width: assert property (@(posedge clock) disable iff (!reset_n)
        $fell(pulse_n) |-> (!pulse_n throughout (1'b1 ##PULSE_HOLD 1'b1))
        ##1 pulse_n)
        else $error("reset pulse width wrong");

endmodule : wcw_reset_pulse
`default_nettype wire

// *** design/wcw_watchdog.sv ***
// Purpose: countdown watchdog with control register
// Assumes: options are static, sampled while reset_n is low
// Notes:   reset_out_n is meant to feed the system reset
`timescale 1ns/100ps
`default_nettype none
module wcw_watchdog #(
    parameter int PRESCALE_CYCLES = wcw_pkg::WCW_PRESCALE_CYCLES,
    parameter int STEP_UNIT       = wcw_pkg::WCW_STEP_UNIT,
    parameter int PULSE_CYCLES    = wcw_pkg::WCW_RESET_PULSE_CYCLES
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output var  logic [7:0] reg_rdata,
    // static options
    input  wire logic       hw_watchdog_option,
    input  wire logic       halt_reset_option,
    // clock controller and core status
    input  wire logic [1:0] timebase_select,
    input  wire logic       rtc_interrupt_enable,
    input  wire logic       halt_exec,
    input  wire logic       wakeup_event,
    // results
    output var  logic       reset_out_n,
    output var  logic       watchdog_active,
    output var  logic       counting_halted
);

    ////////////////////////////////////////////////////////////////////////
    // state

    wcw_pkg::wcw_ctrl_type ctrl;
    wcw_pkg::wcw_halt_type halt_state;
    logic                  hw_opt;
    logic                  halt_opt;
    logic                  halt_step_used;
    logic                  fire;
    logic                  step;

    logic                  ctrl_write;
    logic                  ctrl_read;
    logic                  active_now;
    logic                  count_enable;
    logic                  decrement;
    logic                  timeout_hit;
    logic                  soft_reset;
    logic                  halt_reset;
    logic                  next_fire;

    ////////////////////////////////////////////////////////////////////////
    // step source and pulse stretcher

    // no write input: a reload leaves the prescaler phase alone
    wcw_prescaler #(
        .LONG_CYCLES     (PRESCALE_CYCLES),
        .STEP_UNIT       (STEP_UNIT)
    ) u_prescaler (
        .clock           (clock),
        .reset_n         (reset_n),
        .timebase_select (timebase_select),
        .step            (step)
    );

    wcw_reset_pulse #(
        .PULSE_CYCLES    (PULSE_CYCLES)
    ) u_reset_pulse (
        .clock           (clock),
        .reset_n         (reset_n),
        .start           (fire),
        .pulse_n         (reset_out_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode

    always_comb
    begin
        ctrl_write   = reg_write && (reg_addr == wcw_pkg::WCW_CTRL_ADDR);
        ctrl_read    = reg_read && (reg_addr == wcw_pkg::WCW_CTRL_ADDR);
        active_now   = ctrl.activate || hw_opt;
        // normal halt allows one last step before the counter freezes
        count_enable = (halt_state == wcw_pkg::WCW_RUN) ||
                       ((halt_state == wcw_pkg::WCW_HALT) &&
                        !halt_step_used);
        decrement    = step && count_enable;
        timeout_hit  = decrement && !ctrl_write && active_now &&
                       (ctrl.count == wcw_pkg::WCW_TIMEOUT_AT);
        soft_reset   = ctrl_write &&
                       (reg_wdata[wcw_pkg::WCW_ACT_POS] || active_now) &&
                       !reg_wdata[wcw_pkg::WCW_TOP_POS];
        halt_reset   = halt_exec && active_now && !rtc_interrupt_enable &&
                       halt_opt;
        next_fire    = timeout_hit || soft_reset || halt_reset;
    end

    ////////////////////////////////////////////////////////////////////////
    // options, sampled only while reset is held

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            hw_opt   <= hw_watchdog_option;
            halt_opt <= halt_reset_option;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            ctrl <= wcw_pkg::wcw_ctrl_type'(wcw_pkg::WCW_CTRL_RESET);
        else if (ctrl_write)
        begin
            // a reload beats a step landing in the same cycle
            ctrl.count    <= reg_wdata[wcw_pkg::WCW_COUNT_W-1:0];
            ctrl.activate <= ctrl.activate ||
                             reg_wdata[wcw_pkg::WCW_ACT_POS];
        end
        else if (decrement)
            ctrl.count <= ctrl.count - 7'h01;
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            reg_rdata <= wcw_pkg::WCW_READ_IDLE;
        else if (ctrl_read)
            reg_rdata <= ctrl;
        else
            reg_rdata <= wcw_pkg::WCW_READ_IDLE;
    end

    ////////////////////////////////////////////////////////////////////////
    // reset request

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            fire <= 1'b0;
        else
            fire <= next_fire;
    end

    ////////////////////////////////////////////////////////////////////////
    // halt tracking

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            halt_state     <= wcw_pkg::WCW_RUN;
            halt_step_used <= 1'b0;
        end
        else
        begin
            case (halt_state)
                wcw_pkg::WCW_RUN:
                begin
                    halt_step_used <= 1'b0;
                    if (halt_exec && !halt_reset)
                    begin
                        if (rtc_interrupt_enable)
                            halt_state <= wcw_pkg::WCW_ACTIVE_HALT;
                        else
                            halt_state <= wcw_pkg::WCW_HALT;
                    end
                end
                wcw_pkg::WCW_HALT:
                begin
                    if (decrement)
                        halt_step_used <= 1'b1;
                    if (wakeup_event)
                        halt_state <= wcw_pkg::WCW_RUN;
                end
                wcw_pkg::WCW_ACTIVE_HALT:
                begin
                    if (wakeup_event)
                        halt_state <= wcw_pkg::WCW_RUN;
                end
                default:
                    halt_state <= wcw_pkg::WCW_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status outputs

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            watchdog_active <= 1'b0;
            counting_halted <= 1'b0;
        end
        else
        begin
            watchdog_active <= active_now;
            counting_halted <= !count_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    a_reset_value: assert property (
        $past(!reset_n) |-> ctrl == wcw_pkg::WCW_CTRL_RESET)
        else $error("control not 7Fh after reset");

    a_timeout_pulse: assert property (
        timeout_hit |-> ##2 !reset_out_n)
        else $error("timeout did not pull reset low");

    a_soft_pulse: assert property (
        ctrl_write && reg_wdata[wcw_pkg::WCW_ACT_POS] &&
        !reg_wdata[wcw_pkg::WCW_TOP_POS] |-> ##2 !reset_out_n)
        else $error("software reset not issued");

    a_halt_pulse: assert property (
        halt_exec && ctrl.activate && !rtc_interrupt_enable && halt_opt
        |-> ##2 !reset_out_n)
        else $error("halt reset not issued");

    a_activate_sticky: assert property (
        ctrl.activate |=> ctrl.activate)
        else $error("activation cleared without reset");

    a_write_load: assert property (
        ctrl_write |=> ctrl.count == $past(reg_wdata[6:0]) &&
        ctrl.activate == $past(ctrl.activate || reg_wdata[7]))
        else $error("write did not load control");

    a_active_freeze: assert property (
        halt_state == wcw_pkg::WCW_ACTIVE_HALT && !ctrl_write
        |=> $stable(ctrl.count))
        else $error("counter moved in active halt");

    a_hw_active: assert property (
        hw_opt && reset_n |=> watchdog_active)
        else $error("hardware option not active");

    a_no_step_no_move: assert property (
        !step && !ctrl_write |=> $stable(ctrl.count))
        else $error("counter moved without a step");

    a_quiet_reset: assert property (
        !fire && reset_out_n |=> reset_out_n)
        else $error("reset pulse without request");

    c_timeout: cover property (timeout_hit ##2 !reset_out_n);
    c_soft: cover property (soft_reset);
    c_active_halt: cover property (
        halt_state == wcw_pkg::WCW_ACTIVE_HALT ##1 wakeup_event);
    c_halt_step: cover property (
        halt_state == wcw_pkg::WCW_HALT && decrement);

endmodule : wcw_watchdog
`default_nettype wire

// *** testbench/tb.sv ***
// Purpose: self-checking bench for the countdown watchdog
// Assumes: shortened prescaler (512 cycles, unit 1) and 25-cycle pulse
// Notes:   the bench reapplies reset_n after each watchdog reset pulse but the last
`timescale 1ns/100ps
`default_nettype none
module tb;

    localparam int         PRE   = 512;
    localparam int         PULSE = 25;
    localparam int         LIMIT = 60000;
    localparam logic [7:0] CTRL  = wcw_pkg::WCW_CTRL_ADDR;

    logic       clock;
    logic       reset_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_write;
    logic       reg_read;
    logic [7:0] reg_rdata;
    logic       hw_opt;
    logic       halt_opt;
    logic [1:0] timebase_select;
    logic       rtc;
    logic       halt_exec;
    logic       wakeup_event;
    logic       reset_out_n;
    logic       watchdog_active;
    logic       counting_halted;
    int         failures;
    int         samples_checked;
    int         cycles;
    int         t;
    logic [7:0] d;
    logic [7:0] d2;

    wcw_watchdog #(
        .PRESCALE_CYCLES (PRE),
        .STEP_UNIT       (1),
        .PULSE_CYCLES    (PULSE)
    ) dut_u (
        .clock                (clock),
        .reset_n              (reset_n),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_write            (reg_write),
        .reg_read             (reg_read),
        .reg_rdata            (reg_rdata),
        .hw_watchdog_option   (hw_opt),
        .halt_reset_option    (halt_opt),
        .timebase_select      (timebase_select),
        .rtc_interrupt_enable (rtc),
        .halt_exec            (halt_exec),
        .wakeup_event         (wakeup_event),
        .reset_out_n          (reset_out_n),
        .watchdog_active      (watchdog_active),
        .counting_halted      (counting_halted)
    );

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // hang guard: the longest path is the four timebase runs
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            failures = failures + 1;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("failures %0d samples_checked %0d", failures,
                 samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    task automatic chk_val(input string nm, input logic [7:0] exp,
                           input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_val

    task automatic chk_range(input string nm, input int lo, input int hi,
                             input int got);
        samples_checked++;
        if (got < lo || got > hi)
        begin
            failures++;
            $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask : chk_range

    // shortest step spacing per timebase: 192 plus the short offset
    function automatic int short_len(input logic [1:0] sel);
        case (sel)
            2'h0:    short_len = 251;
            2'h1:    short_len = 245;
            2'h2:    short_len = 227;
            default: short_len = 246;
        endcase
    endfunction : short_len

    // timeout bounds with the scaled prescaler, unit of one cycle
    function automatic int tmo(input logic [1:0] sel, input int cnt,
                               input bit upper);
        int msb;
        int f;
        case (sel)
            2'h0:    msb = 4;
            2'h1:    msb = 8;
            2'h2:    msb = 20;
            default: msb = 49;
        endcase
        f   = (4 * cnt) / msb;
        tmo = PRE * (cnt - f) + short_len(sel) * f;
        if (upper)
            tmo = tmo + PRE;
        else
            tmo = tmo + short_len(sel) - 64;
    endfunction : tmo

    ////////////////////////////////////////////////////////////////////////
    task automatic do_reset(input logic hw, input logic ho);
        @(posedge clock);
        reset_n  <= 1'b0;
        hw_opt   <= hw;
        halt_opt <= ho;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    task automatic strobe(input logic wake);
        @(posedge clock);
        if (wake)
            wakeup_event <= 1'b1;
        else
            halt_exec <= 1'b1;
        @(posedge clock);
        wakeup_event <= 1'b0;
        halt_exec    <= 1'b0;
    endtask : strobe

    // counts edges after the request edge up to the one that samples the
    // pulse low, then its length
    task automatic wait_fire(input int lo, input int hi);
        int n;
        int m;
        n = 1;
        m = 0;
        while (reset_out_n !== 1'b0 && n <= hi)
        begin
            @(posedge clock);
            #1 n++;
        end
        chk_range("fire delay", lo, hi, n);
        while (reset_out_n === 1'b0 && m <= PULSE)
        begin
            @(posedge clock);
            #1 m++;
        end
        chk_range("pulse length", PULSE, PULSE, m);
    endtask : wait_fire

    task automatic no_fire(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n)
        begin
            @(posedge clock);
            #1 if (reset_out_n !== 1'b1) seen = 1'b1;
        end
        chk_val("no reset", 8'h00, {7'h00, seen});
    endtask : no_fire

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        reset_n         = 1'b0;
        reg_addr        = 8'h00;
        reg_wdata       = 8'h00;
        reg_write       = 1'b0;
        reg_read        = 1'b0;
        hw_opt          = 1'b0;
        halt_opt        = 1'b0;
        timebase_select = 2'h0;
        rtc             = 1'b0;
        halt_exec       = 1'b0;
        wakeup_event    = 1'b0;
        failures        = 0;
        samples_checked = 0;
        cycles          = 0;
        void'($urandom(32'h8C53));
        do_reset(1'b0, 1'b1);
        rd(CTRL, d);
        chk_val("control reset", 8'h7F, d);
        chk_val("active flag", 8'h00, {7'h00, watchdog_active});
        rd(8'h10, d);
        chk_val("unmapped read", 8'h00, d);
        wr(8'h10, 8'h80);
        no_fire(40);
        wr(CTRL, 8'h3F);
        rd(CTRL, d);
        chk_val("inactive load", 8'h3F, d);
        no_fire(40);
        wr(CTRL, 8'h80);
        wait_fire(2, 2);
        do_reset(1'b0, 1'b1);
        wr(CTRL, 8'hFF);
        wr(CTRL, 8'h7F);
        rd(CTRL, d);
        chk_val("stay active", 8'hFF, d);
        chk_val("active flag", 8'h01, {7'h00, watchdog_active});
        // every timebase, count 40h first then 40h plus a random offset below 8
        for (int sel = 0; sel < 4; sel++)
        begin
            do_reset(1'b0, 1'b1);
            timebase_select <= sel[1:0];
            t = (sel == 0) ? 0 : int'($urandom % 8);
            wr(CTRL, 8'hC0 | t[7:0]);
            wait_fire(tmo(sel[1:0], t, 1'b0),
                      tmo(sel[1:0], t, 1'b1) + 2);
        end
        do_reset(1'b0, 1'b1);
        repeat (10)
        begin
            wr(CTRL, 8'hC2);
            no_fire(300);
        end
        rd(CTRL, d);
        chk_val("refresh top bits", 8'h03, {6'h00, d[7:6]});
        wr(CTRL, 8'hFF);
        strobe(1'b0);
        wait_fire(2, 2);
        do_reset(1'b0, 1'b1);
        rtc <= 1'b1;
        wr(CTRL, 8'hFF);
        rd(CTRL, d);
        strobe(1'b0);
        no_fire(1500);
        rd(CTRL, d2);
        chk_val("frozen count", d, d2);
        chk_val("halted flag", 8'h01, {7'h00, counting_halted});
        strobe(1'b1);
        repeat (2) @(posedge clock);
        #1 chk_val("halted flag", 8'h00, {7'h00, counting_halted});
        do_reset(1'b0, 1'b0);
        rtc <= 1'b0;
        wr(CTRL, 8'hFF);
        strobe(1'b0);
        no_fire(1500);
        strobe(1'b1);
        do_reset(1'b1, 1'b0);
        repeat (2) @(posedge clock);
        #1 chk_val("active flag", 8'h01, {7'h00, watchdog_active});
        wr(CTRL, 8'h41);
        wait_fire(tmo(timebase_select, 1, 1'b0),
                  tmo(timebase_select, 1, 1'b1) + 2);
        final_report();
    end

endmodule : tb
`default_nettype wire
